//--- led_pkg.sv
`default_nettype none
package led_pkg;
   // blink timing
   localparam int unsigned clock_hz = 100_000_000;
   localparam int unsigned act_blink_hz = 10;
   localparam int unsigned col_blink_hz = 20;
   // half periods in cycles, rounded down
   localparam int unsigned act_half_cycles = clock_hz / (2 * act_blink_hz);
   localparam int unsigned col_half_cycles = clock_hz / (2 * col_blink_hz);
   // reset values
   localparam logic led_off = 1'h0;
   localparam logic wave_start = 1'h0;
   // indicator scheme codes
   typedef enum logic [0:0] {
      scheme_four = 1'h0,
      scheme_three = 1'h1
   } scheme_t;
endpackage : led_pkg
`default_nettype wire

//--- blink_timebase.sv
`timescale 1ns/10ps
`default_nettype none
module blink_timebase #(
   parameter int unsigned half_cycles = led_pkg::act_half_cycles
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // square wave out
   output logic wave
);
   localparam int cnt_w = $clog2(half_cycles + 1);
   localparam logic [cnt_w-1:0] last = cnt_w'(half_cycles - 1);

   logic [cnt_w-1:0] cnt_ff;
   logic [cnt_w-1:0] nxt_cnt;
   logic wave_ff;
   logic nxt_wave;

   // divider next state
   always_comb begin
      nxt_cnt = cnt_ff + cnt_w'(1);
      nxt_wave = wave_ff;
      if (cnt_ff == last) begin
         nxt_cnt = '0;
         nxt_wave = ~wave_ff;
      end
   end

   // divider registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= '0;
         wave_ff <= led_pkg::wave_start;
      end else begin
         cnt_ff <= nxt_cnt;
         wave_ff <= nxt_wave;
      end
   end

   assign wave = wave_ff;
endmodule : blink_timebase
`default_nettype wire

//--- ethernet_status_led_driver.sv
// Summary of operation
// - four-indicator scheme: activity indicator blinks 10 Hz during receive or transmit.
// - three-indicator scheme: link/activity on with good link, blinks 10 Hz on traffic.
// - four-indicator scheme: ten-megabit indicator on while link runs at 10 Mbit/s.
// - four-indicator scheme: hundred-megabit indicator on while link runs at 100 Mbit/s.
// - three-indicator scheme: speed indicator on at 100 Mbit/s, off at 10.
// - duplex/collision on in full duplex; blinks 20 Hz on half-duplex collision.
// - dedicated duplex output idle in three-indicator scheme; shared output carries it.
// - activity blinking follows receive and transmit only, never collisions.
`timescale 1ns/10ps
`default_nettype none
module ethernet_status_led_driver #(
   parameter int unsigned act_half = led_pkg::act_half_cycles,
   parameter int unsigned col_half = led_pkg::col_half_cycles
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // scheme select, high selects three indicators
   input wire logic three_led_scheme,
   // link status from core logic
   input wire logic link_good,
   input wire logic speed_100,
   input wire logic full_duplex,
   input wire logic rx_active,
   input wire logic tx_active,
   input wire logic collision,
   // indicators, high is on
   output logic activity_indicator,
   output logic ten_meg_link_indicator,
   output logic hundred_meg_link_indicator,
   output logic dedicated_duplex_collision_indicator
);

   ////////////////////////////////////////////////////////////////////////////
   // timebases
   //   both waves free-run from reset and are not restarted by traffic, so the
   //   first flash of a burst can be shorter than a half period; this keeps all
   //   activity and collision lamps of one board in step with each other

   logic act_wave;
   logic col_wave;

   // 10 Hz activity wave from divided core clock
   blink_timebase #(.half_cycles(act_half)) u_act_tb (
      .clock(clock),
      .rst_n(rst_n),
      .wave(act_wave)
   );

   // 20 Hz collision wave from divided core clock
   blink_timebase #(.half_cycles(col_half)) u_col_tb (
      .clock(clock),
      .rst_n(rst_n),
      .wave(col_wave)
   );

   ////////////////////////////////////////////////////////////////////////////
   // scheme decode
   //   the select is a level from core logic on this clock, read with no
   //   synchroniser; a change shows on the pins one edge later

   led_pkg::scheme_t scheme;

   // select to scheme code
   always_comb begin
      scheme = led_pkg::scheme_four;
      if (three_led_scheme) begin
         scheme = led_pkg::scheme_three;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // shared terms
   //   collisions are kept out of the activity term on purpose; a half-duplex
   //   collision only ever reaches the duplex/collision lamp, and a collision
   //   seen in full duplex is ignored because the lamp is steady then

   logic traffic;
   logic act_blink;
   logic dup_col;

   // activity term, frames only
   always_comb begin
      traffic = rx_active | tx_active;
      act_blink = traffic & act_wave;
   end

   // duplex term, steady or collision blink
   always_comb begin
      if (full_duplex) begin
         dup_col = 1'h1;
      end else begin
         dup_col = collision & col_wave;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // indicators
   //   each pin is its own group: a next value and a register, dark in reset;
   //   the three-indicator scheme moves duplex/collision onto the ten-megabit
   //   pin and leaves the dedicated pin dark

   logic nxt_act;
   logic nxt_ten;
   logic nxt_hundred;
   logic nxt_dedicated;
   logic act_ff;
   logic ten_ff;
   logic hundred_ff;
   logic dedicated_ff;

   // activity pin next value
   always_comb begin
      nxt_act = led_pkg::led_off;
      case (scheme)
         led_pkg::scheme_four: begin
            nxt_act = act_blink;
         end
         led_pkg::scheme_three: begin
            // traffic blink overrides steady link
            nxt_act = traffic ? act_wave : link_good;
         end
         default: begin
            nxt_act = led_pkg::led_off;
         end
      endcase
   end

   // activity pin register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         act_ff <= led_pkg::led_off;
      end else begin
         act_ff <= nxt_act;
      end
   end

   // ten-megabit pin next value, shared duplex pin in three-indicator scheme
   always_comb begin
      nxt_ten = led_pkg::led_off;
      case (scheme)
         led_pkg::scheme_four: begin
            nxt_ten = link_good & ~speed_100;
         end
         led_pkg::scheme_three: begin
            nxt_ten = dup_col;
         end
         default: begin
            nxt_ten = led_pkg::led_off;
         end
      endcase
   end

   // ten-megabit pin register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ten_ff <= led_pkg::led_off;
      end else begin
         ten_ff <= nxt_ten;
      end
   end

   // hundred-megabit pin next value, speed pin in three-indicator scheme
   always_comb begin
      nxt_hundred = led_pkg::led_off;
      case (scheme)
         led_pkg::scheme_four: begin
            nxt_hundred = link_good & speed_100;
         end
         led_pkg::scheme_three: begin
            // speed alone, not gated by link
            nxt_hundred = speed_100;
         end
         default: begin
            nxt_hundred = led_pkg::led_off;
         end
      endcase
   end

   // hundred-megabit pin register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hundred_ff <= led_pkg::led_off;
      end else begin
         hundred_ff <= nxt_hundred;
      end
   end

   // dedicated duplex/collision pin next value, idle in three-indicator scheme
   always_comb begin
      nxt_dedicated = led_pkg::led_off;
      case (scheme)
         led_pkg::scheme_four: begin
            nxt_dedicated = dup_col;
         end
         led_pkg::scheme_three: begin
            nxt_dedicated = led_pkg::led_off;
         end
         default: begin
            nxt_dedicated = led_pkg::led_off;
         end
      endcase
   end

   // dedicated duplex/collision pin register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dedicated_ff <= led_pkg::led_off;
      end else begin
         dedicated_ff <= nxt_dedicated;
      end
   end

   // pins straight from the registers
   assign activity_indicator = act_ff;
   assign ten_meg_link_indicator = ten_ff;
   assign hundred_meg_link_indicator = hundred_ff;
   assign dedicated_duplex_collision_indicator = dedicated_ff;
endmodule : ethernet_status_led_driver
`default_nettype wire

//--- led_chk_sva.sv
`timescale 1ns/10ps
`default_nettype none
module led_chk (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // status inputs
   input wire logic three_led_scheme,
   input wire logic link_good,
   input wire logic speed_100,
   input wire logic full_duplex,
   input wire logic rx_active,
   input wire logic tx_active,
   input wire logic collision,
   // indicators
   input wire logic activity_indicator,
   input wire logic ten_meg_link_indicator,
   input wire logic hundred_meg_link_indicator,
   input wire logic dedicated_duplex_collision_indicator
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // short aliases
   wire t = three_led_scheme, l = link_good, s = speed_100, f = full_duplex, q = rx_active | tx_active;
   wire a = activity_indicator, n = ten_meg_link_indicator, h = hundred_meg_link_indicator;
   wire d = dedicated_duplex_collision_indicator, c = collision;
   property p_act; !t && !q |=> !a; endproperty
   a_act: assert property (p_act) else $error("activity lit idle");
   property p_lnk; t && !q |=> a == $past(l); endproperty
   a_lnk: assert property (p_lnk) else $error("link lamp wrong");
   property p_ten; !t |=> n == $past(l && !s); endproperty
   a_ten: assert property (p_ten) else $error("ten lamp wrong");
   property p_hun; !t |=> h == $past(l && s); endproperty
   a_hun: assert property (p_hun) else $error("hundred lamp wrong");
   property p_spd; t |=> h == $past(s); endproperty
   a_spd: assert property (p_spd) else $error("speed lamp wrong");
   property p_fd; f && !t |=> d; endproperty
   a_fd: assert property (p_fd) else $error("duplex lamp off");
   property p_ded; t |=> !d; endproperty
   a_ded: assert property (p_ded) else $error("dedicated lamp lit");
   property p_sh; f && t |=> n; endproperty
   a_sh: assert property (p_sh) else $error("shared lamp off");
   property p_hdx; !f && !c && !t |=> !d; endproperty
   a_hdx: assert property (p_hdx) else $error("dedicated lamp lit without collision");
   property p_shx; !f && !c && t |=> !n; endproperty
   a_shx: assert property (p_shx) else $error("shared lamp lit without collision");
endmodule : led_chk
bind ethernet_status_led_driver led_chk u_led_chk (.*);
`default_nettype wire

//--- led_board.sv
`timescale 1ns/10ps
`default_nettype none
module led_board (
   // clock and lamp drives
   input wire logic clock,
   input wire logic [3:0] lit,
   // turn-ons seen per lamp
   output logic [3:0][7:0] flashes
);
   logic [3:0] was_ff = 4'h0;
   logic [3:0][7:0] count_ff = '0;
   // count each lamp turning on
   always @(posedge clock) begin
      for (int i = 0; i < 4; i++) begin
         if (lit[i] && !was_ff[i]) begin
            count_ff[i] <= count_ff[i] + 8'h01;
         end
      end
      was_ff <= lit;
   end
   assign flashes = count_ff;
endmodule : led_board
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clock = 1'h0, rst_n = 1'h0, three = 1'h0, link = 1'h0, spd = 1'h0, fd = 1'h0, rx = 1'h0, tx = 1'h0;
   logic col = 1'h0, act, ten, hun, ded;
   logic [3:0][7:0] fl, base;
   int fails = 0, check_count = 0;
   always #5 clock = ~clock;
   ethernet_status_led_driver #(.act_half(8), .col_half(4)) u_ethernet_status_led_driver (.clock(clock),
      .rst_n(rst_n), .three_led_scheme(three), .link_good(link), .speed_100(spd), .full_duplex(fd),
      .rx_active(rx), .tx_active(tx), .collision(col), .activity_indicator(act), .ten_meg_link_indicator(ten),
      .hundred_meg_link_indicator(hun), .dedicated_duplex_collision_indicator(ded));
   led_board u_led_board (.clock(clock), .lit({act, ten, hun, ded}), .flashes(fl));
   task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results
   // steady lamps over every scheme, link, speed and duplex setting
   task automatic t_steady;
      for (int i = 0; i < 16; i++) begin
         @(posedge clock) {three, link, spd, fd} <= 4'(i);
         repeat (2) @(negedge clock);
         chk("activity", act, three & link);
         chk("ten", ten, three ? fd : link & ~spd);
         chk("hundred", hun, three ? spd : link & spd);
         chk("dedicated", ded, ~three & fd);
      end
      $display("steady test done");
   endtask : t_steady
   // traffic with half-duplex collision, counted over four blink periods
   task automatic t_blink(input logic sch);
      @(posedge clock) {three, link, fd, rx, tx, col} <= {sch, 2'h2, ~sch, sch, 1'h1};
      repeat (16) @(posedge clock);
      @(posedge act);
      @(negedge clock) base = fl;
      repeat (64) @(negedge clock);
      chk("activity flashes", fl[3] - base[3], 8'h04);
      chk("collision flashes", sch ? fl[2] - base[2] : fl[0] - base[0], 8'h08);
      @(posedge clock) {rx, tx} <= 2'h0;
      repeat (3) @(negedge clock);
      chk("activity collision only", act, sch);
      @(posedge clock) col <= 1'h0;
      $display("blink test done");
   endtask : t_blink
   initial begin
      repeat (6) @(posedge clock);
      rst_n <= 1'h1;
      t_steady;
      t_blink(1'h0);
      t_blink(1'h1);
      results;
   end
   // watchdog
   initial begin
      #20us;
      fails++;
      results;
   end
endmodule : tb_top
`default_nettype wire
